// [rtl/param_read_top.sv]
// Purpose: Serial read path for the discoverable-parameter store
// Assumes: Serial clock well below a quarter of clk_i (160 ns in the bench)
// Notes:   All serial input pins pass two flops; edges found on the sampled clock

`timescale 1ns/1ps

// Operation
// - Opcode 5Ah after select starts a parameter read; others are ignored.
// - Only address bits 10 to 0 select a byte; higher bits dropped.
// - Opcode and address bits are sampled on serial clock rising edges.
// - First output bit on fall of clock 39, counted from 0; later on falls.
// - Address advances by one after each byte; output runs while clocked.
// - Select high ends the read; output is released while deselected.
// - Bytes 00h-03h read 53h, 46h, 44h, 50h.
// - Minor revision 05h at 04h, major revision 01h at 05h.
// - Header count 02h at 06h; byte 07h reads FFh.
// - First header 08h-0Bh reads 00h, 00h, 01h, 10h.
// - First pointer 0Ch-0Eh reads 40h, 00h, 00h; 0Fh reads FFh.
// - Second header: vendor id, 00h, 01h, 04h at 10h-13h.
// - Vendor pointer 14h-16h reads C0h, 00h, 00h; 17h reads FFh.
// - Basic table word at 40h reads E5h, 20h, 91h, FFh.
module param_read_top #(
  parameter int         ADDR_W    = param_pkg::ADDR_W,
  parameter logic [7:0] VENDOR_ID = 8'h3c // Arbitrary value
) (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic cs_n_i,
  input  wire logic sck_i,
  input  wire logic si_i,
  output logic      so_o,
  output logic      so_oe_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Elaboration check: the store needs 40h reachable, shifter holds 24 bits
  if (ADDR_W < 7 || ADDR_W > param_pkg::SHIFT_W)
  begin : g_bad_width
    $error("ADDR_W must lie between 7 and 24");
  end

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_CMD,
    ST_ADDR,
    ST_DUMMY,
    ST_DATA,
    ST_SKIP
  } state_t;

  logic [1:0]                  cs_sync_q;
  logic [1:0]                  sck_sync_q;
  logic [1:0]                  si_sync_q;
  logic                        sck_prev_q;
  logic                        cs_n_s;
  logic                        si_s;
  logic                        rise;
  logic                        fall;
  state_t                      state_q;
  logic [5:0]                  rcnt_q;
  logic [param_pkg::SHIFT_W-1:0] sh_q;
  logic [7:0]                  opcode;
  logic [ADDR_W-1:0]           addr_q;
  logic [2:0]                  bit_q;
  logic [6:0]                  out_sh_q;
  logic                        load;

  rom_if #(.ADDR_W(ADDR_W)) rif ();

  ////////////////////////////////////////////////////////////////////////////
  // Two-flop synchronisers; edge detect looks only at the second stage
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      cs_sync_q  <= 2'h3;
      sck_sync_q <= 2'h0;
      si_sync_q  <= 2'h0;
      sck_prev_q <= 1'b0;
    end
    else
    begin
      cs_sync_q  <= {cs_sync_q[0], cs_n_i};
      sck_sync_q <= {sck_sync_q[0], sck_i};
      si_sync_q  <= {si_sync_q[0], si_i};
      sck_prev_q <= sck_sync_q[1];
    end
  end

  // Sampled pin levels and serial clock edges
  assign cs_n_s = cs_sync_q[1];
  assign si_s   = si_sync_q[1];
  assign rise   = sck_sync_q[1] & ~sck_prev_q;
  assign fall   = ~sck_sync_q[1] & sck_prev_q;
  assign opcode = {sh_q[6:0], si_s};

  ////////////////////////////////////////////////////////////////////////////
  // Transaction sequencer
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      state_q <= ST_IDLE;
    else if (cs_n_s)
      state_q <= ST_IDLE;
    else
    begin
      case (state_q)
        ST_IDLE:
          state_q <= ST_CMD;
        ST_CMD:
          if (rise && rcnt_q == param_pkg::CNT_OP_LAST)
            state_q <= (opcode == param_pkg::OP_READ_PARAMS) ?
                       ST_ADDR : ST_SKIP;
        ST_ADDR:
          if (rise && rcnt_q == param_pkg::CNT_ADDR_LAST)
            state_q <= ST_DUMMY;
        ST_DUMMY:
          if (fall && rcnt_q == param_pkg::CNT_OUT_FIRST)
            state_q <= ST_DATA; // Input not looked at here
        ST_DATA:
          state_q <= ST_DATA;
        ST_SKIP:
          state_q <= ST_SKIP;
        default:
          state_q <= ST_IDLE;
      endcase
    end
  end

  // Rising edge counter, saturating at 28h on the 40th rising edge
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      rcnt_q <= 6'h00;
    else if (cs_n_s)
      rcnt_q <= 6'h00;
    else if (rise && rcnt_q != param_pkg::CNT_SAT)
      rcnt_q <= rcnt_q + 6'h01;
  end

  // Opcode and address shifter, MSB first on rising edges
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      sh_q <= '0;
    else if (rise && (state_q == ST_CMD || state_q == ST_ADDR))
      sh_q <= {sh_q[param_pkg::SHIFT_W-2:0], si_s};
  end

  ////////////////////////////////////////////////////////////////////////////
  // Byte address: low bits latched at the last address bit, then advanced
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      addr_q <= '0;
    else if (state_q == ST_ADDR && rise &&
             rcnt_q == param_pkg::CNT_ADDR_LAST)
      addr_q <= {sh_q[ADDR_W-2:0], si_s};
    else if (state_q == ST_DATA && fall && bit_q == param_pkg::BIT_LAST)
      addr_q <= addr_q + ADDR_W'(1);
  end

  assign rif.addr = addr_q;

  // A new byte is taken from the store at a byte boundary fall
  assign load = fall &&
                ((state_q == ST_DUMMY &&
                  rcnt_q == param_pkg::CNT_OUT_FIRST) ||
                 (state_q == ST_DATA && bit_q == 3'h0));

  ////////////////////////////////////////////////////////////////////////////
  // Output shifter, changes only on falling edges, released when deselected
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      so_o     <= 1'b0;
      so_oe_o  <= 1'b0;
      out_sh_q <= 7'h00;
      bit_q    <= 3'h0;
    end
    else if (cs_n_s)
    begin
      so_o     <= 1'b0;
      so_oe_o  <= 1'b0;
      out_sh_q <= 7'h00;
      bit_q    <= 3'h0;
    end
    else if (load)
    begin
      so_o     <= rif.rdata[7];
      so_oe_o  <= 1'b1;
      out_sh_q <= rif.rdata[6:0];
      bit_q    <= 3'h1;
    end
    else if (fall && state_q == ST_DATA)
    begin
      so_o     <= out_sh_q[6];
      out_sh_q <= {out_sh_q[5:0], 1'b0};
      bit_q    <= bit_q + 3'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Parameter store
  param_rom #(
    .ADDR_W    (ADDR_W),
    .VENDOR_ID (VENDOR_ID)
  ) u_rom (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .bus   (rif.store)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  op_accept_a: assert property (@(posedge clk_i) disable iff (rst_i)
    state_q == ST_CMD && !cs_n_s && rise &&
    rcnt_q == param_pkg::CNT_OP_LAST && opcode == 8'h5a
    |=> state_q == ST_ADDR)
    else $error("read opcode not accepted");

  op_reject_a: assert property (@(posedge clk_i) disable iff (rst_i)
    state_q == ST_CMD && !cs_n_s && rise &&
    rcnt_q == param_pkg::CNT_OP_LAST && opcode != 8'h5a
    |=> state_q == ST_SKIP)
    else $error("foreign opcode not ignored");

  skip_quiet_a: assert property (@(posedge clk_i) disable iff (rst_i)
    state_q == ST_SKIP |=> !so_oe_o)
    else $error("output driven after foreign opcode");

  addr_mask_a: assert property (@(posedge clk_i) disable iff (rst_i)
    state_q == ST_ADDR && !cs_n_s && rise && rcnt_q == 6'h1f
    |=> addr_q == {$past(sh_q[ADDR_W-2:0]), $past(si_s)})
    else $error("address low bits not latched");

  rise_only_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !rise |=> $stable(sh_q))
    else $error("shifter moved without rising edge");

  first_out_a: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(so_oe_o) |-> $past(fall) && $past(rcnt_q) == 6'h28 &&
                      $past(state_q) == ST_DUMMY)
    else $error("output began at wrong edge");

  out_fall_a: assert property (@(posedge clk_i) disable iff (rst_i)
    so_oe_o && $changed(so_o) |-> $past(fall))
    else $error("output changed off a falling edge");

  addr_step_a: assert property (@(posedge clk_i) disable iff (rst_i)
    state_q == ST_DATA && !cs_n_s && fall && bit_q == 3'h7
    |=> addr_q == $past(addr_q) + ADDR_W'(1))
    else $error("address not advanced after byte");

  release_a: assert property (@(posedge clk_i) disable iff (rst_i)
    cs_n_s |=> !so_oe_o && state_q == ST_IDLE)
    else $error("output driven while deselected");

  msb_first_a: assert property (@(posedge clk_i) disable iff (rst_i)
    load && !cs_n_s |=> so_o == $past(rif.rdata[7]) ##0
    out_sh_q == $past(rif.rdata[6:0]))
    else $error("byte not sent MSB first");

endmodule // param_read_top

// [include/param_pkg.sv]
// Purpose: Shared constants for the discoverable-parameter read path
// Assumes: Serial clock sampled by a 50 MHz system clock
// Notes:   Parameter store contents and serial frame counts live here

package param_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Frame layout, counted in serial clock rising edges
  localparam int         ADDR_W        = 11;
  localparam int         SHIFT_W       = 24;
  localparam logic [7:0] OP_READ_PARAMS = 8'h5a;
  localparam logic [5:0] CNT_OP_LAST   = 6'h07; // 8th edge ends opcode
  localparam logic [5:0] CNT_ADDR_LAST = 6'h1f; // 32nd edge ends address
  localparam logic [5:0] CNT_OUT_FIRST = 6'h28; // Fall after full dummy byte
  localparam logic [5:0] CNT_SAT       = 6'h28;
  localparam logic [2:0] BIT_LAST      = 3'h7;

  ////////////////////////////////////////////////////////////////////////////
  // Parameter store contents
  localparam logic [7:0] FILL_BYTE = 8'hff;
  localparam int         HDR_LEN   = 24;
  localparam logic [10:0] VEND_ADDR = 11'h010;
  localparam logic [8:0] BPT_WORD  = 9'h010; // Word address of 40h
  localparam logic [7:0] HDR_ROM [0:23] = '{
    8'h53, 8'h46, 8'h44, 8'h50, // Signature
    8'h05, 8'h01, 8'h02, 8'hff, // Revisions, header count
    8'h00, 8'h00, 8'h01, 8'h10, // First header
    8'h40, 8'h00, 8'h00, 8'hff, // First table pointer
    8'h00, 8'h00, 8'h01, 8'h04, // Vendor header, id replaced
    8'hc0, 8'h00, 8'h00, 8'hff  // Vendor table pointer
  };
  localparam logic [7:0] BPT_ROM [0:3] = '{
    8'he5, 8'h20, 8'h91, 8'hff  // First basic table word
  };

endpackage

// [include/rom_if.sv]
// Purpose: Address and read data between read path and parameter store
// Assumes: Read data registered one clock after the address
// Notes:   Store drives data, reader drives address

`timescale 1ns/1ps

interface rom_if #(
  parameter int ADDR_W = 11
);
  logic [ADDR_W-1:0] addr;
  logic [7:0]        rdata;

  modport reader (output addr, input rdata);
  modport store  (input addr, output rdata);
endinterface

// [rtl/param_rom.sv]
// Purpose: Fixed discoverable-parameter store with registered read data
// Assumes: Address stable for at least one clock before use
// Notes:   Unprogrammed locations read as all ones

`timescale 1ns/1ps

module param_rom #(
  parameter int         ADDR_W    = param_pkg::ADDR_W,
  parameter logic [7:0] VENDOR_ID = 8'h3c // Arbitrary value
) (
  input  wire logic clk_i,
  input  wire logic rst_i,
  rom_if.store      bus
);

  logic [7:0] byte_d;
  logic [7:0] rdata_q;

  ////////////////////////////////////////////////////////////////////////////
  // Decode the full address; only header and first table word are defined
  always_comb
  begin
    byte_d = param_pkg::FILL_BYTE;
    if (bus.addr < ADDR_W'(param_pkg::HDR_LEN))
    begin
      if (bus.addr == ADDR_W'(param_pkg::VEND_ADDR))
        byte_d = VENDOR_ID;
      else
        byte_d = param_pkg::HDR_ROM[bus.addr[4:0]];
    end
    else if (bus.addr[ADDR_W-1:2] == (ADDR_W-2)'(param_pkg::BPT_WORD))
      byte_d = param_pkg::BPT_ROM[bus.addr[1:0]];
  end

  // Read data register
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      rdata_q <= 8'h00;
    else
      rdata_q <= byte_d;
  end

  assign bus.rdata = rdata_q;

  ////////////////////////////////////////////////////////////////////////////
  // Checks on store contents
  sig_byte_a: assert property (@(posedge clk_i) disable iff (rst_i)
    bus.addr == ADDR_W'(11'h003) |=> bus.rdata == 8'h50)
    else $error("signature byte 3 wrong");

  hdr_count_a: assert property (@(posedge clk_i) disable iff (rst_i)
    bus.addr == ADDR_W'(11'h006) |=> bus.rdata == 8'h02)
    else $error("header count byte wrong");

  ptr_vendor_a: assert property (@(posedge clk_i) disable iff (rst_i)
    bus.addr == ADDR_W'(11'h014) |=> bus.rdata == 8'hc0)
    else $error("vendor pointer byte wrong");

  bpt_erase_a: assert property (@(posedge clk_i) disable iff (rst_i)
    bus.addr == ADDR_W'(11'h041) |=> bus.rdata == 8'h20)
    else $error("basic table erase opcode wrong");

endmodule // param_rom

// [verif/spi_host_model.sv]
// Purpose: Host controller model that runs parameter-read frames
// Assumes: Mode 0, serial clock half period of four clk_i cycles
// Notes:   Data is taken late in the high phase, once the output settled

`timescale 1ns/1ps

module spi_host_model (
  input  wire logic clk_i,
  input  wire logic so_i,
  input  wire logic so_oe_i,
  output logic      cs_n_o,
  output logic      sck_o,
  output logic      si_o
);
  logic [7:0] rx [0:31];
  logic       oe_low;
  logic       oe_high;
  logic       oe_early;

  // Idle: deselected, serial clock low
  initial
  begin
    cs_n_o = 1'b1;
    sck_o  = 1'b0;
    si_o   = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // One serial clock period; a bit goes out while the clock is low
  task automatic tick(input logic b, output logic q, output logic oe);
    si_o = b;
    repeat (4) @(negedge clk_i);
    sck_o = 1'b1;
    repeat (3) @(negedge clk_i);
    q  = so_i;
    oe = so_oe_i;
    @(negedge clk_i);
    sck_o = 1'b0;
  endtask

  // Whole frame: command, address, dummy, then data bits and a tail
  task automatic frame(input logic [7:0] op, input logic [23:0] addr,
                       input int nbytes, input int tail);
    logic [31:0] cmd;
    logic        q;
    logic        oe;
    cmd     = {op, addr};
    q       = 1'b0;
    oe_low  = 1'b0;
    oe_high = 1'b0;
    oe_early = 1'b0;
    cs_n_o  = 1'b0;
    repeat (4) @(negedge clk_i);
    for (int i = 31; i >= 0; i--)
      tick(cmd[i], q, oe);
    // Dummy clocks carry a toggling pattern the device must ignore
    for (int i = 0; i < 8; i++)
    begin
      tick(i[0], q, oe);
      if (oe !== 1'b0)
        oe_early = 1'b1;
    end
    for (int k = 0; k < nbytes * 8 + tail; k++)
    begin
      tick(~q, q, oe);
      if (k < nbytes * 8)
        rx[k / 8] = {rx[k / 8][6:0], q};
      if (oe !== 1'b1)
        oe_low = 1'b1;
      if (oe !== 1'b0)
        oe_high = 1'b1;
    end
    repeat (4) @(negedge clk_i);
    cs_n_o = 1'b1;
    si_o   = ~si_o;
  endtask
endmodule // spi_host_model

// [verif/spi_flash_discoverable_param_read_bench.sv]
// Purpose: Self-checking bench for the parameter read path
// Assumes: 50 MHz clk_i, 160 ns serial clock from the host model
// Notes:   Expected store bytes are written out here by hand

`timescale 1ns/1ps

module spi_flash_discoverable_param_read_bench;
  localparam logic [7:0] VENDOR = 8'h3c; // Arbitrary value
  logic       clk_i;
  logic       rst_i;
  logic       cs_n;
  logic       sck;
  logic       si;
  logic       so;
  logic       so_oe;
  int         fail_count;
  int         n_checks;
  int         cycles;
  logic [7:0] hdr [0:23] = '{
    8'h53, 8'h46, 8'h44, 8'h50, 8'h05, 8'h01, 8'h02, 8'hff,
    8'h00, 8'h00, 8'h01, 8'h10, 8'h40, 8'h00, 8'h00, 8'hff,
    VENDOR, 8'h00, 8'h01, 8'h04, 8'hc0, 8'h00, 8'h00, 8'hff};
  logic [7:0] bpt [0:3] = '{8'he5, 8'h20, 8'h91, 8'hff};

  param_read_top #(.VENDOR_ID(VENDOR)) DUT (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .cs_n_i  (cs_n),
    .sck_i   (sck),
    .si_i    (si),
    .so_o    (so),
    .so_oe_o (so_oe)
  );

  spi_host_model host (
    .clk_i   (clk_i),
    .so_i    (so),
    .so_oe_i (so_oe),
    .cs_n_o  (cs_n),
    .sck_o   (sck),
    .si_o    (si)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Clock and hang guard
  initial
  begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end

  always @(posedge clk_i)
  begin
    cycles++;
    if (cycles == 8000)
    begin
      fail_count++;
      results();
    end
  end

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Output released a few clocks after deselect
  task automatic idle_check;
    repeat (6) @(negedge clk_i);
    check({6'h00, so_oe, so}, 8'h00);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_header;
    host.frame(8'h5a, 24'h000000, 24, 0);
    for (int i = 0; i < 24; i++)
      check(host.rx[i], hdr[i]);
    check({7'h00, host.oe_low}, 8'h00);
    check({7'h00, host.oe_early}, 8'h00);
    idle_check();
  endtask

  // Upper address bits set, partial byte before deselect
  task automatic t_high_bits;
    host.frame(8'h5a, 24'hfff840, 4, 3);
    for (int i = 0; i < 4; i++)
      check(host.rx[i], bpt[i]);
    idle_check();
  endtask

  // Start mid-header so the run crosses a word boundary
  task automatic t_mid;
    host.frame(8'h5a, 24'h00000a, 3, 0);
    for (int i = 0; i < 3; i++)
      check(host.rx[i], hdr[10 + i]);
    idle_check();
  endtask

  // Foreign opcode 5Bh never enables the output
  task automatic t_bad_op;
    host.frame(8'h5b, 24'h000000, 2, 0);
    check({7'h00, host.oe_high}, 8'h00);
    idle_check();
  endtask

  task automatic results;
    if (fail_count == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    fail_count = 0;
    n_checks   = 0;
    cycles     = 0;
    rst_i      = 1'b1;
    repeat (3) @(posedge clk_i);
    @(negedge clk_i);
    rst_i = 1'b0;
    check({6'h00, so_oe, so}, 8'h00);
    t_header();
    t_high_bits();
    t_bad_op();
    t_mid();
    results();
  end
endmodule // spi_flash_discoverable_param_read_bench
